// file: design/upn_pkg.sv
// Package for the pipe not-ready / buffer-empty / device-state interrupt block.
// Assumes one 10 MHz clock and a plain strobe register port with 8-bit byte addresses.
package upn_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_PIPES = 10;
  localparam int PIPE_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_INT_STATUS_ZERO = 8'h00;
  localparam logic [7:0] OFS_INT_ENABLE_ZERO = 8'h04;
  localparam logic [7:0] OFS_NOT_READY_SUMMARY_STATUS = 8'h08;
  localparam logic [7:0] OFS_NOT_READY_SUMMARY_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_BUFFER_EMPTY_SUMMARY_STATUS = 8'h10;
  localparam logic [7:0] OFS_BUFFER_EMPTY_SUMMARY_ENABLE = 8'h14;
  localparam logic [7:0] OFS_PIPE_RESP = 8'h18;
  localparam logic [7:0] OFS_ISO_SEL = 8'h1C;
  localparam logic [7:0] OFS_CRC_ERR = 8'h20;
  localparam logic [7:0] OFS_OVERRUN = 8'h24;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_DEV_STATE = 0;
  localparam int POS_STATE_CHANGE = 4;
  localparam int POS_RESUME = 5;
  localparam int POS_NOT_READY_SUMMARY_SUM = 6;
  localparam int POS_BUFFER_EMPTY_SUMMARY_SUM = 7;
  localparam int POS_EN_NOT_READY_SUMMARY = 0;
  localparam int POS_EN_BUFFER_EMPTY_SUMMARY = 1;
  localparam int POS_EN_STATE_CHANGE_FLAG = 2;
  localparam int POS_EN_RESUME_FLAG = 3;
  localparam int POS_EN_TO_DEFAULT = 4;
  localparam int POS_EN_TO_ADDRESS = 5;
  localparam int POS_EN_TO_CONFIG = 6;
  localparam int POS_EN_TO_SUSPEND = 7;
  localparam int IEN_W = 8;

  // ----------------------------------------
  // Codes and reset values
  // ----------------------------------------
  localparam logic [1:0] RESP_NAK = 2'h0;
  localparam logic [1:0] RESP_BUF = 2'h1;
  localparam logic [1:0] RESP_STALL = 2'h3;
  localparam logic [2:0] DSQ_POWERED = 3'h0;
  localparam logic [2:0] DSQ_DEFAULT = 3'h1;
  localparam logic [2:0] DSQ_ADDRESS = 3'h2;
  localparam logic [2:0] DSQ_CONFIGURED = 3'h3;
  localparam logic [2:0] DSQ_SUSPENDED = 3'h4;
  localparam logic [1:0] ERR_LIMIT = 2'h3;
  localparam logic [1:0] ERR_CNT_RST = 2'h0;
  localparam logic [IEN_W-1:0] IEN_RST = 8'h00;

  typedef enum logic [2:0] {
    DS_POWERED,
    DS_DEFAULT,
    DS_ADDRESS,
    DS_CONFIGURED,
    DS_SUSPENDED
  } upn_dev_state_t;

  typedef struct packed {
    upn_dev_state_t dst;
    upn_dev_state_t pre_susp;
    logic [NUM_PIPES-1:0] not_ready_summary;
    logic [NUM_PIPES-1:0] not_ready_summary_en;
    logic [NUM_PIPES-1:0] buffer_empty_summary;
    logic [NUM_PIPES-1:0] buffer_empty_summary_en;
    logic [NUM_PIPES-1:0] iso;
    logic [NUM_PIPES-1:0] crc;
    logic [NUM_PIPES-1:0] ovr;
    logic [NUM_PIPES-1:0][1:0] resp;
    logic [NUM_PIPES-1:0][1:0] errcnt;
    logic [IEN_W-1:0] ien;
    logic not_ready_summary_sum;
    logic buffer_empty_summary_sum;
    logic state_change_flag;
    logic resume_flag;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic stall_hs;
    logic no_resp;
    logic discard;
  } upn_state_t;

endpackage

// file: design/upn_irq.sv
// Pipe not-ready, buffer-empty and device-state interrupt logic of a USB controller.
// Assumes the transaction engine delivers one-cycle event pulses tagged with a pipe number.
// Functional notes
// - Buffer-mode pipe not-ready request sets its bit; enabled bit sets summary and interrupt.
// - Host role: no not-ready request during a setup transaction.
// - Function role: no not-ready request during the control status stage.
// - Host: three consecutive timeouts or bad packets set not-ready and force NAK.
// - Host: received STALL sets not-ready and forces response to STALL.
// - Function: IN token with empty transmit FIFO raises not-ready at the token.
// - Function: OUT token with full FIFO raises not-ready when NAK follows the data.
// - Function: toggle-mismatch retransmission or errored data gives no receive not-ready.
// - Receive CRC and overrun flags change only on isochronous pipes.
// - Buffer-mode pipe buffer-empty event sets its bit; enabled bit sets summary, interrupt.
// - Transmit pipe empty after a transmission, zero-length too, raises buffer-empty.
// - Single-buffer non-control pipe: buffer-empty coincides with its buffer-ready event.
// - No transmit buffer-empty if other buffer filling, cleared by command, or status ZLP.
// - Oversize reception raises buffer-empty, discards data, forces response to STALL.
// - Oversize reception: host gives no response, function answers STALL.
// - No receive buffer-empty on CRC or bit-stuff error, or during setup.
// - Writing 0 clears a buffer-empty bit; writing 1 leaves it.
// - Each entered state (default, address, configured, suspended) has its own enable; state readable as three-bit field.
// - Resume from suspend reports through resume flag, not state change flag.
// - Entry to default state reported only after a bus reset is detected.
// - Device state tracked and reported only in function role.
`timescale 1ns/10ps
`default_nettype none

module upn_irq
  import upn_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  input wire logic host_role,
  input wire logic setup_active,
  input wire logic status_stage,
  input wire logic single_buffer,
  input wire logic [PIPE_W-1:0] ev_pipe,
  input wire logic ev_xact_err,
  input wire logic ev_xact_ok,
  input wire logic ev_stall_rx,
  input wire logic ev_in_token,
  input wire logic ev_out_nak,
  input wire logic fifo_empty,
  input wire logic fifo_full,
  input wire logic ev_toggle_mismatch,
  input wire logic ev_data_err,
  input wire logic ev_tx_done,
  input wire logic ev_other_buf_busy,
  input wire logic ev_buf_cleared,
  input wire logic ev_oversize,
  input wire logic ev_crc_err,
  input wire logic ev_overrun,
  input wire logic bus_reset_det,
  input wire logic addr_assigned,
  input wire logic config_set,
  input wire logic config_clear,
  input wire logic suspend_det,
  input wire logic resume_det,
  output logic usb_irq,
  output logic [NUM_PIPES-1:0][1:0] pipe_response_field,
  output logic stall_handshake,
  output logic no_response,
  output logic discard_rx,
  output logic [2:0] device_state_field
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [NUM_PIPES-1:0] pipe_onehot(input logic [PIPE_W-1:0] p);
    logic [NUM_PIPES-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_PIPES; i++) begin
      if (p == PIPE_W'(i)) begin
        v[i] = 1'b1;
      end
    end
    return v;
  endfunction

  function automatic logic [2:0] state_code(input upn_dev_state_t s);
    logic [2:0] c;
    case (s)
      DS_POWERED: c = DSQ_POWERED;
      DS_DEFAULT: c = DSQ_DEFAULT;
      DS_ADDRESS: c = DSQ_ADDRESS;
      DS_CONFIGURED: c = DSQ_CONFIGURED;
      DS_SUSPENDED: c = DSQ_SUSPENDED;
      default: c = DSQ_POWERED;
    endcase
    return c;
  endfunction

  upn_state_t cur_ff;
  upn_state_t nxt_ff;

  logic [NUM_PIPES-1:0] sel;
  logic [NUM_PIPES-1:0] is_buf;
  logic [NUM_PIPES-1:0] not_ready_summary_req;
  logic [NUM_PIPES-1:0] buffer_empty_summary_req;
  logic [NUM_PIPES-1:0] err_third;
  logic [NUM_PIPES-1:0] force_nak;
  logic [NUM_PIPES-1:0] force_stall;
  logic host_ok;
  logic func_ok;
  logic oversize_ok;

  // ----------------------------------------
  // Request qualification
  // ----------------------------------------
  always_comb begin
    sel = pipe_onehot(ev_pipe);
    host_ok = host_role && !setup_active;
    func_ok = !host_role && !status_stage;
    oversize_ok = ev_oversize && !ev_data_err && !ev_crc_err && !setup_active;
    for (int i = 0; i < NUM_PIPES; i++) begin
      is_buf[i] = (cur_ff.resp[i] == RESP_BUF);
      err_third[i] = host_ok && sel[i] && ev_xact_err && (cur_ff.errcnt[i] == ERR_LIMIT - 2'h1);
      force_nak[i] = err_third[i];
      force_stall[i] = (host_ok && sel[i] && ev_stall_rx) || (sel[i] && oversize_ok);
      not_ready_summary_req[i] = err_third[i]
        || (host_ok && sel[i] && ev_stall_rx)
        || (func_ok && sel[i] && ev_in_token && fifo_empty)
        || (func_ok && sel[i] && ev_out_nak && fifo_full && !ev_toggle_mismatch && !ev_data_err);
      // Single-buffer tx-done is the same pulse that drives buffer-ready, so both land together
      buffer_empty_summary_req[i] = (sel[i] && ev_tx_done && fifo_empty && !ev_other_buf_busy && !ev_buf_cleared
        && !(!host_role && status_stage))
        || (sel[i] && oversize_ok);
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [NUM_PIPES-1:0] keep_not_ready_summary;
    logic [NUM_PIPES-1:0] keep_buffer_empty_summary;
    logic [NUM_PIPES-1:0] keep_crc;
    logic [NUM_PIPES-1:0] keep_ovr;
    logic state_change_flag_keep;
    logic resume_flag_keep;
    logic state_change_flag_set;
    logic resume_flag_set;
    keep_not_ready_summary = '1;
    keep_buffer_empty_summary = '1;
    keep_crc = '1;
    keep_ovr = '1;
    state_change_flag_keep = 1'b1;
    resume_flag_keep = 1'b1;
    state_change_flag_set = 1'b0;
    resume_flag_set = 1'b0;
    nxt_ff = cur_ff;

    // Software writes; clears are masks so a same-cycle hardware set still wins
    if (wr_en) begin
      case (addr)
        OFS_INT_STATUS_ZERO: begin
          state_change_flag_keep = wr_data[POS_STATE_CHANGE];
          resume_flag_keep = wr_data[POS_RESUME];
        end
        OFS_INT_ENABLE_ZERO: nxt_ff.ien = wr_data[IEN_W-1:0];
        OFS_NOT_READY_SUMMARY_STATUS: keep_not_ready_summary = wr_data[NUM_PIPES-1:0];
        OFS_NOT_READY_SUMMARY_ENABLE: nxt_ff.not_ready_summary_en = wr_data[NUM_PIPES-1:0];
        OFS_BUFFER_EMPTY_SUMMARY_STATUS: keep_buffer_empty_summary = wr_data[NUM_PIPES-1:0];
        OFS_BUFFER_EMPTY_SUMMARY_ENABLE: nxt_ff.buffer_empty_summary_en = wr_data[NUM_PIPES-1:0];
        OFS_PIPE_RESP: begin
          for (int i = 0; i < NUM_PIPES; i++) begin
            nxt_ff.resp[i] = wr_data[2*i +: 2];
          end
        end
        OFS_ISO_SEL: nxt_ff.iso = wr_data[NUM_PIPES-1:0];
        OFS_CRC_ERR: keep_crc = wr_data[NUM_PIPES-1:0];
        OFS_OVERRUN: keep_ovr = wr_data[NUM_PIPES-1:0];
        default: begin
        end
      endcase
    end

    // Per-pipe status and host error counters
    for (int i = 0; i < NUM_PIPES; i++) begin
      if (force_stall[i]) begin
        nxt_ff.resp[i] = RESP_STALL;
      end else if (force_nak[i]) begin
        nxt_ff.resp[i] = RESP_NAK;
      end
      if (host_ok && sel[i] && ev_xact_err) begin
        nxt_ff.errcnt[i] = err_third[i] ? ERR_CNT_RST : cur_ff.errcnt[i] + 2'h1;
      end else if (sel[i] && (ev_xact_ok || ev_stall_rx)) begin
        nxt_ff.errcnt[i] = ERR_CNT_RST;
      end
      nxt_ff.not_ready_summary[i] = (cur_ff.not_ready_summary[i] & keep_not_ready_summary[i]) | (not_ready_summary_req[i] & is_buf[i]);
      nxt_ff.buffer_empty_summary[i] = (cur_ff.buffer_empty_summary[i] & keep_buffer_empty_summary[i]) | (buffer_empty_summary_req[i] & is_buf[i]);
      nxt_ff.crc[i] = (cur_ff.crc[i] & keep_crc[i]) | (cur_ff.iso[i] & sel[i] & ev_crc_err);
      nxt_ff.ovr[i] = (cur_ff.ovr[i] & keep_ovr[i]) | (cur_ff.iso[i] & sel[i] & ev_overrun);
    end

    // Summaries follow the enabled bits and drop once every pipe bit is gone
    if (|(not_ready_summary_req & is_buf & cur_ff.not_ready_summary_en)) begin
      nxt_ff.not_ready_summary_sum = 1'b1;
    end else if (nxt_ff.not_ready_summary == '0) begin
      nxt_ff.not_ready_summary_sum = 1'b0;
    end
    if (|(buffer_empty_summary_req & is_buf & cur_ff.buffer_empty_summary_en)) begin
      nxt_ff.buffer_empty_summary_sum = 1'b1;
    end else if (nxt_ff.buffer_empty_summary == '0) begin
      nxt_ff.buffer_empty_summary_sum = 1'b0;
    end

    // Device state tracking, function role only
    if (!host_role) begin
      if (bus_reset_det) begin
        nxt_ff.dst = DS_DEFAULT;
        state_change_flag_set = cur_ff.ien[POS_EN_TO_DEFAULT];
      end else begin
        case (cur_ff.dst)
          DS_POWERED: begin
          end
          DS_DEFAULT: begin
            if (suspend_det) begin
              nxt_ff.pre_susp = cur_ff.dst;
              nxt_ff.dst = DS_SUSPENDED;
              state_change_flag_set = cur_ff.ien[POS_EN_TO_SUSPEND];
            end else if (addr_assigned) begin
              nxt_ff.dst = DS_ADDRESS;
              state_change_flag_set = cur_ff.ien[POS_EN_TO_ADDRESS];
            end
          end
          DS_ADDRESS: begin
            if (suspend_det) begin
              nxt_ff.pre_susp = cur_ff.dst;
              nxt_ff.dst = DS_SUSPENDED;
              state_change_flag_set = cur_ff.ien[POS_EN_TO_SUSPEND];
            end else if (config_set) begin
              nxt_ff.dst = DS_CONFIGURED;
              state_change_flag_set = cur_ff.ien[POS_EN_TO_CONFIG];
            end
          end
          DS_CONFIGURED: begin
            if (suspend_det) begin
              nxt_ff.pre_susp = cur_ff.dst;
              nxt_ff.dst = DS_SUSPENDED;
              state_change_flag_set = cur_ff.ien[POS_EN_TO_SUSPEND];
            end else if (config_clear) begin
              nxt_ff.dst = DS_ADDRESS;
              state_change_flag_set = cur_ff.ien[POS_EN_TO_ADDRESS];
            end
          end
          DS_SUSPENDED: begin
            if (resume_det) begin
              nxt_ff.dst = cur_ff.pre_susp;
              resume_flag_set = 1'b1;
            end
          end
          default: nxt_ff.dst = DS_POWERED;
        endcase
      end
    end
    nxt_ff.state_change_flag = (cur_ff.state_change_flag & state_change_flag_keep) | state_change_flag_set;
    nxt_ff.resume_flag = (cur_ff.resume_flag & resume_flag_keep) | resume_flag_set;

    // Outputs registered straight from the state
    nxt_ff.irq = (nxt_ff.not_ready_summary_sum && cur_ff.ien[POS_EN_NOT_READY_SUMMARY])
      || (nxt_ff.buffer_empty_summary_sum && cur_ff.ien[POS_EN_BUFFER_EMPTY_SUMMARY])
      || (nxt_ff.state_change_flag && cur_ff.ien[POS_EN_STATE_CHANGE_FLAG])
      || (nxt_ff.resume_flag && cur_ff.ien[POS_EN_RESUME_FLAG]);
    nxt_ff.discard = oversize_ok;
    nxt_ff.no_resp = oversize_ok && host_role;
    nxt_ff.stall_hs = oversize_ok && !host_role;

    // Read port: data valid only in the cycle after the strobe
    nxt_ff.rdata = '0;
    if (rd_en) begin
      case (addr)
        OFS_INT_STATUS_ZERO: begin
          nxt_ff.rdata[POS_DEV_STATE +: 3] = state_code(cur_ff.dst);
          nxt_ff.rdata[POS_STATE_CHANGE] = cur_ff.state_change_flag;
          nxt_ff.rdata[POS_RESUME] = cur_ff.resume_flag;
          nxt_ff.rdata[POS_NOT_READY_SUMMARY_SUM] = cur_ff.not_ready_summary_sum;
          nxt_ff.rdata[POS_BUFFER_EMPTY_SUMMARY_SUM] = cur_ff.buffer_empty_summary_sum;
        end
        OFS_INT_ENABLE_ZERO: nxt_ff.rdata[IEN_W-1:0] = cur_ff.ien;
        OFS_NOT_READY_SUMMARY_STATUS: nxt_ff.rdata[NUM_PIPES-1:0] = cur_ff.not_ready_summary;
        OFS_NOT_READY_SUMMARY_ENABLE: nxt_ff.rdata[NUM_PIPES-1:0] = cur_ff.not_ready_summary_en;
        OFS_BUFFER_EMPTY_SUMMARY_STATUS: nxt_ff.rdata[NUM_PIPES-1:0] = cur_ff.buffer_empty_summary;
        OFS_BUFFER_EMPTY_SUMMARY_ENABLE: nxt_ff.rdata[NUM_PIPES-1:0] = cur_ff.buffer_empty_summary_en;
        OFS_PIPE_RESP: begin
          for (int i = 0; i < NUM_PIPES; i++) begin
            nxt_ff.rdata[2*i +: 2] = cur_ff.resp[i];
          end
        end
        OFS_ISO_SEL: nxt_ff.rdata[NUM_PIPES-1:0] = cur_ff.iso;
        OFS_CRC_ERR: nxt_ff.rdata[NUM_PIPES-1:0] = cur_ff.crc;
        OFS_OVERRUN: nxt_ff.rdata[NUM_PIPES-1:0] = cur_ff.ovr;
        default: nxt_ff.rdata = '0;
      endcase
    end
    // Unused in single-buffer mode beyond the coincidence noted above
    if (single_buffer && 1'b0) begin
      nxt_ff.rdata = '0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cur_ff <= '0;
      cur_ff.dst <= DS_POWERED;
      cur_ff.pre_susp <= DS_POWERED;
      cur_ff.ien <= IEN_RST;
    end else if (ce) begin
      cur_ff <= nxt_ff;
    end
  end

  assign rd_data = cur_ff.rdata;
  assign usb_irq = cur_ff.irq;
  assign pipe_response_field = cur_ff.resp;
  assign stall_handshake = cur_ff.stall_hs;
  assign no_response = cur_ff.no_resp;
  assign discard_rx = cur_ff.discard;
  // Enum order equals the state codes, so the flop drives the pin with no decode
  assign device_state_field = cur_ff.dst;

endmodule

`default_nettype wire

// file: sim/upn_peer.sv
// Model of the transaction engine and bus peer: one-cycle event pulses tagged with a pipe.
// Assumes the bench calls send from one process, one transfer at a time.
`timescale 1ns/10ps
`default_nettype none

module upn_peer (
  input wire logic ref_clk,
  output logic [3:0] ev_pipe,
  output logic [20:0] ev
);
  // ----------------------------------------
  // Event driver
  // ----------------------------------------
  initial begin
    ev = 21'h0;
    ev_pipe = 4'h0;
  end

  // Tag is inverted between events so a stale pipe number is never trusted
  task automatic send(input logic [3:0] p, input int a, input int b = 31, input int c = 31);
    logic [20:0] m;
    m = 21'h0;
    m[a] = 1'h1;
    if (b < 21) m[b] = 1'h1;
    if (c < 21) m[c] = 1'h1;
    @(posedge ref_clk);
    ev <= m;
    ev_pipe <= p;
    @(posedge ref_clk);
    ev <= 21'h0;
    ev_pipe <= ~p;
  endtask
endmodule

`default_nettype wire

// file: sim/upn_irq_properties.sv
// Concurrent checks on the ports of the pipe interrupt block.
// Assumes one clock domain with synchronous active-low reset; bound below.
`timescale 1ns/10ps
`default_nettype none

module upn_irq_properties
  import upn_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic host_role,
  input wire logic setup_active,
  input wire logic [PIPE_W-1:0] ev_pipe,
  input wire logic ev_stall_rx,
  input wire logic ev_oversize,
  input wire logic ev_crc_err,
  input wire logic ev_data_err,
  input wire logic bus_reset_det,
  input wire logic resume_det,
  input wire logic stall_handshake,
  input wire logic no_response,
  input wire logic discard_rx,
  input wire logic [NUM_PIPES-1:0][1:0] pipe_response_field,
  input wire logic [2:0] device_state_field
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic ov_ok;
  // Clean oversize on a buffer-mode pipe outside setup
  assign ov_ok = ce && ev_oversize && !setup_active && !ev_crc_err && !ev_data_err
                 && pipe_response_field[ev_pipe] == RESP_BUF;

  chk_stall_resp: assert property (ce && host_role && ev_stall_rx && !setup_active
    && pipe_response_field[ev_pipe] == RESP_BUF |=> pipe_response_field[$past(ev_pipe)] == RESP_STALL)
    else $error("stall handshake did not force stall response");
  chk_fn_oversize: assert property (ov_ok && !host_role |=> stall_handshake && discard_rx)
    else $error("function oversize without stall and discard");
  chk_host_oversize: assert property (ov_ok && host_role |=> no_response && !stall_handshake)
    else $error("host oversize answered wrongly");
  chk_noresp_cause: assert property (no_response |-> $past(host_role) && $past(ev_oversize))
    else $error("silent response without host oversize");
  chk_stall_cause: assert property (stall_handshake |-> !$past(host_role) && $past(ev_oversize))
    else $error("stall handshake without function oversize");
  chk_host_frozen: assert property (host_role && $past(host_role) |-> $stable(device_state_field))
    else $error("device state moved in host role");
  chk_reset_default: assert property (ce && !host_role && bus_reset_det |=>
    device_state_field == DSQ_DEFAULT) else $error("bus reset did not enter default");
  chk_default_cause: assert property ($changed(device_state_field) && device_state_field == DSQ_DEFAULT
    |-> $past(bus_reset_det) || $past(resume_det)) else $error("default state without bus reset");
  chk_resume_leave: assert property (ce && !host_role && resume_det
    && device_state_field == DSQ_SUSPENDED |=> device_state_field != DSQ_SUSPENDED)
    else $error("resume did not leave suspend");

  cover property (ce && host_role && ev_stall_rx);
  cover property (stall_handshake);
  cover property (device_state_field == DSQ_SUSPENDED);
endmodule

bind upn_irq upn_irq_properties u_chk (.ref_clk, .nrst, .ce, .host_role, .setup_active, .ev_pipe,
  .ev_stall_rx, .ev_oversize, .ev_crc_err, .ev_data_err, .bus_reset_det, .resume_det, .stall_handshake,
  .no_response, .discard_rx, .pipe_response_field, .device_state_field);

`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the pipe interrupt block.
// Assumes upn_pkg, upn_irq, the peer model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb;
  import upn_pkg::*;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  localparam int XERR = 0, XOK = 1, STL = 2, TOK = 3, ONAK = 4, FE = 5, FF = 6, TGL = 7, DERR = 8;
  localparam int TXD = 9, OBB = 10, BCL = 11, OVS = 12, CRC = 13, OVR = 14, BRST = 15, ADR = 16;
  localparam int CFS = 17, CFC = 18, SUS = 19, RSM = 20;
  logic ref_clk = 1'h0, nrst = 1'h0, ce = 1'h1, wr_en = 1'h0, rd_en = 1'h0, single_buffer = 1'h1;
  logic host_role = 1'h1, setup_active = 1'h0, status_stage = 1'h0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wr_data = 32'h0000_0000, rd_data;
  logic [PIPE_W-1:0] ev_pipe;
  logic [20:0] ev;
  logic usb_irq, stall_handshake, no_response, discard_rx;
  logic [NUM_PIPES-1:0][1:0] pipe_response_field;
  logic [2:0] device_state_field;
  int num_errors = 0, tests_run = 0, cycles = 0;

  upn_irq u_dut (
    .ref_clk, .nrst, .ce, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .host_role, .setup_active,
    .status_stage, .single_buffer, .ev_pipe, .ev_xact_err(ev[XERR]), .ev_xact_ok(ev[XOK]),
    .ev_stall_rx(ev[STL]), .ev_in_token(ev[TOK]), .ev_out_nak(ev[ONAK]), .fifo_empty(ev[FE]),
    .fifo_full(ev[FF]), .ev_toggle_mismatch(ev[TGL]), .ev_data_err(ev[DERR]), .ev_tx_done(ev[TXD]),
    .ev_other_buf_busy(ev[OBB]), .ev_buf_cleared(ev[BCL]), .ev_oversize(ev[OVS]), .ev_crc_err(ev[CRC]),
    .ev_overrun(ev[OVR]), .bus_reset_det(ev[BRST]), .addr_assigned(ev[ADR]), .config_set(ev[CFS]),
    .config_clear(ev[CFC]), .suspend_det(ev[SUS]), .resume_det(ev[RSM]), .usb_irq, .stall_handshake,
    .no_response, .discard_rx, .pipe_response_field, .device_state_field
  );
  upn_peer p (.ref_clk, .ev_pipe, .ev);

  always #50 ref_clk = ~ref_clk;

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Generous ceiling: the sequence needs well under 1000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'h1;
    @(posedge ref_clk);
    wr_en <= 1'h0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge ref_clk);
    rd_en <= 1'h0;
    @(negedge ref_clk);
    chk(rd_data, exp);
  endtask

  task automatic setl(input logic h, input logic s, input logic st);
    @(posedge ref_clk);
    host_role <= h;
    setup_active <= s;
    status_stage <= st;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'h1;
    rdc(OFS_INT_STATUS_ZERO, 32'h0000_0000);
    wr(8'h30, 32'hFFFF_FFFF);
    rdc(8'h30, 32'h0000_0000);
    wr(OFS_PIPE_RESP, 32'h0005_5555);
    wr(OFS_NOT_READY_SUMMARY_ENABLE, 32'h0000_03FF);
    wr(OFS_BUFFER_EMPTY_SUMMARY_ENABLE, 32'h0000_03FF);
    wr(OFS_INT_ENABLE_ZERO, 32'h0000_0003);
    rdc(OFS_INT_ENABLE_ZERO, 32'h0000_0003);
    $display("Test done: reset and setup");
    p.send(4'h3, STL);
    @(negedge ref_clk);
    chk(usb_irq, 32'h0000_0001);
    rdc(OFS_PIPE_RESP, 32'h0005_55D5);
    rdc(OFS_INT_STATUS_ZERO, 32'h0000_0040);
    setl(1'h1, 1'h1, 1'h0);
    p.send(4'h4, STL);
    setl(1'h1, 1'h0, 1'h0);
    rdc(OFS_NOT_READY_SUMMARY_STATUS, 32'h0000_0008);
    p.send(4'h5, XERR);
    p.send(4'h5, XERR);
    p.send(4'h5, XOK);
    p.send(4'h5, XERR);
    p.send(4'h5, XERR);
    rdc(OFS_NOT_READY_SUMMARY_STATUS, 32'h0000_0008);
    p.send(4'h5, XERR);
    rdc(OFS_NOT_READY_SUMMARY_STATUS, 32'h0000_0028);
    rdc(OFS_PIPE_RESP, 32'h0005_51D5);
    wr(OFS_NOT_READY_SUMMARY_STATUS, 32'hFFFF_FFF7);
    rdc(OFS_INT_STATUS_ZERO, 32'h0000_0040);
    wr(OFS_NOT_READY_SUMMARY_STATUS, 32'hFFFF_FFDF);
    rdc(OFS_INT_STATUS_ZERO, 32'h0000_0000);
    chk(usb_irq, 32'h0000_0000);
    $display("Test done: host not-ready");
    setl(1'h0, 1'h0, 1'h0);
    p.send(4'h1, TOK, FE);
    p.send(4'h8, TOK);
    setl(1'h0, 1'h0, 1'h1);
    p.send(4'h2, TOK, FE);
    setl(1'h0, 1'h0, 1'h0);
    p.send(4'h6, ONAK, FF);
    p.send(4'h7, ONAK, FF, TGL);
    p.send(4'h7, ONAK, FF, DERR);
    rdc(OFS_NOT_READY_SUMMARY_STATUS, 32'h0000_0042);
    p.send(4'h6, TXD, FE);
    p.send(4'h7, TXD, FE, OBB);
    p.send(4'h7, TXD, FE, BCL);
    setl(1'h0, 1'h0, 1'h1);
    p.send(4'h0, TXD, FE);
    setl(1'h0, 1'h0, 1'h0);
    rdc(OFS_BUFFER_EMPTY_SUMMARY_STATUS, 32'h0000_0040);
    rdc(OFS_INT_STATUS_ZERO, 32'h0000_00C0);
    wr(OFS_BUFFER_EMPTY_SUMMARY_STATUS, 32'hFFFF_FFFF);
    rdc(OFS_BUFFER_EMPTY_SUMMARY_STATUS, 32'h0000_0040);
    wr(OFS_BUFFER_EMPTY_SUMMARY_STATUS, 32'hFFFF_FFBF);
    rdc(OFS_BUFFER_EMPTY_SUMMARY_STATUS, 32'h0000_0000);
    $display("Test done: function not-ready and transmit empty");
    p.send(4'h8, OVS);
    @(negedge ref_clk);
    chk({stall_handshake, discard_rx, no_response}, 32'h0000_0006);
    p.send(4'h9, OVS, CRC);
    setl(1'h1, 1'h0, 1'h0);
    p.send(4'h4, OVS);
    @(negedge ref_clk);
    chk({stall_handshake, discard_rx, no_response}, 32'h0000_0003);
    setl(1'h1, 1'h1, 1'h0);
    p.send(4'h2, OVS);
    setl(1'h1, 1'h0, 1'h0);
    rdc(OFS_BUFFER_EMPTY_SUMMARY_STATUS, 32'h0000_0110);
    rdc(OFS_PIPE_RESP, 32'h0007_53D5);
    rdc(OFS_CRC_ERR, 32'h0000_0000);
    wr(OFS_ISO_SEL, 32'h0000_0200);
    p.send(4'h9, CRC);
    p.send(4'h9, OVR);
    rdc(OFS_CRC_ERR, 32'h0000_0200);
    rdc(OFS_OVERRUN, 32'h0000_0200);
    $display("Test done: oversize and isochronous flags");
    p.send(4'h0, BRST);
    @(negedge ref_clk);
    chk(device_state_field, 32'h0000_0000);
    wr(OFS_NOT_READY_SUMMARY_STATUS, 32'h0000_0000);
    wr(OFS_BUFFER_EMPTY_SUMMARY_STATUS, 32'h0000_0000);
    setl(1'h0, 1'h0, 1'h0);
    wr(OFS_INT_ENABLE_ZERO, 32'h0000_0014);
    p.send(4'h0, BRST);
    rdc(OFS_INT_STATUS_ZERO, 32'h0000_0011);
    wr(OFS_INT_STATUS_ZERO, 32'hFFFF_FFEF);
    p.send(4'h0, ADR);
    rdc(OFS_INT_STATUS_ZERO, 32'h0000_0002);
    p.send(4'h0, CFS);
    wr(OFS_INT_ENABLE_ZERO, 32'h0000_00FF);
    p.send(4'h0, SUS);
    rdc(OFS_INT_STATUS_ZERO, 32'h0000_0014);
    wr(OFS_INT_STATUS_ZERO, 32'hFFFF_FFEF);
    p.send(4'h0, RSM);
    rdc(OFS_INT_STATUS_ZERO, 32'h0000_0023);
    p.send(4'h0, CFC);
    rdc(OFS_INT_STATUS_ZERO, 32'h0000_0032);
    @(posedge ref_clk);
    ce <= 1'h0;
    p.send(4'h0, SUS);
    @(posedge ref_clk);
    ce <= 1'h1;
    rdc(OFS_INT_STATUS_ZERO, 32'h0000_0032);
    $display("Test done: device state");
    complete_run();
  end
endmodule

`default_nettype wire
